// ### core/drive_status_pkg.sv
// Package: bit positions, telegram codes, reset values and carrier types of the status word packer
package drive_status_pkg;

	// ==================== Widths and reset values ====================
	localparam int              WORD_W     = 16;
	localparam int              TEL_W      = 8;
	localparam int              LIFE_W     = 4;
	localparam logic [15:0]     WORD_RESET = 16'h0000;
	localparam logic [3:0]      LIFE_RESET = 4'h0;
	localparam logic [3:0]      LIFE_STEP  = 4'h1;

	// ==================== Telegram numbers ====================
	localparam logic [7:0]      TEL_GEN1   = 8'h01;
	localparam logic [7:0]      TEL_GEN3   = 8'h03;
	localparam logic [7:0]      TEL_SPD102 = 8'h66;
	localparam logic [7:0]      TEL_SPD105 = 8'h69;
	localparam logic [7:0]      TEL_POS111 = 8'h6f;

	// ==================== Primary status word bits ====================
	localparam int              PSW_ON_READY    = 0;
	localparam int              PSW_READY_RUN   = 1;
	localparam int              PSW_RUN_EN      = 2;
	localparam int              PSW_FAULT       = 3;
	localparam int              PSW_NO_COAST    = 4;
	localparam int              PSW_NO_QUICK    = 5;
	localparam int              PSW_SW_INHIBIT  = 6;
	localparam int              PSW_ALARM       = 7;
	localparam int              PSW_TOL         = 8;
	localparam int              PSW_CTRL_REQ    = 9;
	localparam int              PSW_REACHED     = 10;
	localparam int              PSW_REF_SET     = 11;
	localparam int              PSW_TASK_ACK    = 12;
	localparam int              PSW_STANDSTILL  = 13;
	localparam int              PSW_TORQUE_CTRL = 14;

	// ==================== Secondary and auxiliary word bits ====================
	localparam int              SSW_RAMP_BYPASS = 4;
	localparam int              SSW_BRAKE_OPEN  = 5;
	localparam int              SSW_INTEG_INH   = 6;
	localparam int              SSW_FIXED_STOP  = 8;
	localparam int              SSW_LIFE_LSB    = 12;
	localparam int              AUX_INCHING     = 10;
	localparam int              AUX_HOMING      = 11;
	localparam int              AUX_DIRECT_SP   = 15;

	// ==================== Reserved bit masks per layout ====================
	localparam logic [15:0]     RSV_PRI_GENERAL = 16'hf800;
	localparam logic [15:0]     RSV_PRI_SPEED   = 16'hb800;
	localparam logic [15:0]     RSV_PRI_POS     = 16'hc000;
	localparam logic [15:0]     RSV_SEC_GENERAL = 16'h0eff;
	localparam logic [15:0]     RSV_SEC_SPEED   = 16'h0e8f;
	localparam logic [15:0]     RSV_AUX         = 16'h73ff;

	// ==================== Types ====================
	typedef enum logic [1:0] {LAYOUT_NONE, LAYOUT_GENERAL, LAYOUT_SPEED, LAYOUT_POS} layout_t;

	typedef enum logic [1:0] {ACK_IDLE, ACK_DROP, ACK_SET} ack_state_t;

	typedef struct packed {
		logic servo_ready;
		logic ready_to_run;
		logic run_enabled;
		logic fault;
		logic coast_stop_command;
		logic quick_stop_command;
		logic switch_on_inhibit;
		logic alarm;
		logic speed_in_tol;
		logic control_request;
		logic compare_reached;
		logic torque_ctrl;
		logic follow_err_in_tol;
		logic target_reached;
		logic ref_point_set;
		logic standstill;
		logic fixed_stop_active;
		logic ramp_bypassed;
		logic brake_released;
		logic integ_inhibited;
		logic inching_function;
		logic homing_active;
		logic direct_setpoint_input_mode;
	} drive_state_t;

	typedef struct packed {
		layout_t primary;
		layout_t secondary;
		logic    aux_en;
		logic    supported;
	} layout_sel_t;

endpackage

// ### core/telegram_layout_decoder.sv
// Decoder from telegram number to the word layouts it uses
`timescale 1ns/1ps
`default_nettype none
module telegram_layout_decoder (
	// Telegram selection
	input  wire logic [7:0]                   telegram,
	// Layout choice
	output var  drive_status_pkg::layout_sel_t sel
);
	import drive_status_pkg::*;

	// ==================== Layout table ====================
	// Unknown telegrams map to no layout so every word reads zero
	always_comb begin
		sel = '{primary: LAYOUT_NONE, secondary: LAYOUT_NONE, aux_en: 1'b0, supported: 1'b0};
		if (telegram == TEL_GEN1 || telegram == TEL_GEN3) begin
			sel = '{primary: LAYOUT_GENERAL, secondary: LAYOUT_GENERAL, aux_en: 1'b0, supported: 1'b1};
		end else if (telegram == TEL_SPD102 || telegram == TEL_SPD105) begin
			sel = '{primary: LAYOUT_SPEED, secondary: LAYOUT_SPEED, aux_en: 1'b0, supported: 1'b1};
		end else if (telegram == TEL_POS111) begin
			sel = '{primary: LAYOUT_POS, secondary: LAYOUT_GENERAL, aux_en: 1'b1, supported: 1'b1};
		end
	end

endmodule
`default_nettype wire

// ### core/life_sign_counter.sv
// Four-bit slave life sign counter, one step per transmitted cycle
`timescale 1ns/1ps
`default_nettype none
module life_sign_counter (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// Cycle strobe
	input  wire logic       step,
	// Count
	output logic [3:0]      count
);
	import drive_status_pkg::*;

	// ==================== Counter ====================
	// Wraps from 15 to 0 by plain 4-bit overflow
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			count <= LIFE_RESET;
		end else if (step) begin
			count <= count + LIFE_STEP;
		end
	end

endmodule
`default_nettype wire

// ### core/drive_status_word_packer.sv
// Packer of the cyclic status words a servo drive returns to its fieldbus host
// Function
// - primary layout: speed for 102/105, positioning 111
// - secondary general for 1/3/111, extended 102/105
// - primary bits 0,1,2,9: ready, run, enable, request
// - primary bits 3,6,7: fault, inhibit, alarm
// - bits 4,5 set when stop commands inactive
// - speed bit 8: speed deviation within tolerance
// - speed bit 10: compare threshold reached
// - speed bit 14: torque control active
// - positioning bit 8: following error within tolerance
// - positioning bit 10: target position reached
// - positioning bit 11: reference point established
// - positioning bit 12 rises on task acceptance
// - positioning bit 13: drive at standstill
// - secondary bit 8: fixed stop travel active
// - secondary bits 15:12 carry slave life sign
// - extended secondary bit 4: ramp generator bypassed
// - extended bits 5,6: brake released, integrator inhibited
// - auxiliary bit 10: inching function active
// - auxiliary bit 11: homing active
// - auxiliary bit 15 follows direct setpoint mode
`timescale 1ns/1ps
`default_nettype none
module drive_status_word_packer (
	// Clock and reset
	input  wire logic                          CLK_SYS,
	input  wire logic                          RESET_N,
	// Telegram selection
	input  wire logic [7:0]                    TELEGRAM,
	// Communication cycle strobe
	input  wire logic                          CYCLE_TICK,
	// Drive state
	input  wire drive_status_pkg::drive_state_t DRIVE_STATE,
	// Positioning task handshake
	input  wire logic                          TASK_ACTIVATE,
	input  wire logic                          TASK_ACCEPTED,
	// Status words
	output logic [15:0]                        PRIMARY_STATUS_WORD,
	output logic [15:0]                        SECONDARY_STATUS_WORD,
	output logic [15:0]                        POSITIONING_AUX_STATUS_WORD,
	output logic                               STATUS_VALID,
	output logic                               TELEGRAM_UNSUPPORTED
);
	import drive_status_pkg::*;

	layout_sel_t  sel;
	layout_sel_t  sent_sel;
	logic [3:0]   life;
	ack_state_t   ack_state;
	ack_state_t   next_ack_state;
	logic         ack_bit;
	logic [15:0]  next_primary;
	logic [15:0]  next_secondary;
	logic [15:0]  next_aux;

	// ==================== Submodules ====================
	telegram_layout_decoder u_decoder (
		.telegram (TELEGRAM),
		.sel      (sel)
	);

	// Life sign steps only on cycles that actually send a word
	life_sign_counter u_life (
		.clk     (CLK_SYS),
		.reset_n (RESET_N),
		.step    (CYCLE_TICK),
		.count   (life)
	);

	// ==================== Task acknowledge handshake ====================
	// Bit 12 rises when a task is taken and falls when the host drops its
	// activate request. A task taken while the bit is still high first sends
	// one cycle with the bit low, so the host always sees a fresh rising edge.
	always_comb begin
		next_ack_state = ack_state;
		case (ack_state)
			ACK_IDLE: begin
				if (TASK_ACCEPTED) begin
					next_ack_state = ACK_SET;
				end
			end
			ACK_SET: begin
				if (TASK_ACCEPTED) begin
					next_ack_state = ACK_DROP;
				end else if (!TASK_ACTIVATE) begin
					next_ack_state = ACK_IDLE;
				end
			end
			ACK_DROP: begin
				if (CYCLE_TICK) begin
					next_ack_state = ACK_SET;
				end
			end
			default: begin
				next_ack_state = ACK_IDLE;
			end
		endcase
		if (sel.primary != LAYOUT_POS) begin
			next_ack_state = ACK_IDLE;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			ack_state <= ACK_IDLE;
		end else begin
			ack_state <= next_ack_state;
		end
	end

	assign ack_bit = (ack_state == ACK_SET);

	// ==================== Primary word assembly ====================
	// Reserved bits stay at zero because the word starts from zero
	always_comb begin
		next_primary = WORD_RESET;
		if (sel.primary != LAYOUT_NONE) begin
			next_primary[PSW_ON_READY]   = DRIVE_STATE.servo_ready;
			next_primary[PSW_READY_RUN]  = DRIVE_STATE.ready_to_run;
			next_primary[PSW_RUN_EN]     = DRIVE_STATE.run_enabled;
			next_primary[PSW_CTRL_REQ]   = DRIVE_STATE.control_request;
			next_primary[PSW_FAULT]      = DRIVE_STATE.fault;
			next_primary[PSW_SW_INHIBIT] = DRIVE_STATE.switch_on_inhibit;
			next_primary[PSW_ALARM]      = DRIVE_STATE.alarm;
			next_primary[PSW_NO_COAST]   = !DRIVE_STATE.coast_stop_command;
			next_primary[PSW_NO_QUICK]   = !DRIVE_STATE.quick_stop_command;
		end
		if (sel.primary == LAYOUT_GENERAL || sel.primary == LAYOUT_SPEED) begin
			next_primary[PSW_TOL]     = DRIVE_STATE.speed_in_tol;
			next_primary[PSW_REACHED] = DRIVE_STATE.compare_reached;
		end
		if (sel.primary == LAYOUT_SPEED) begin
			next_primary[PSW_TORQUE_CTRL] = DRIVE_STATE.torque_ctrl;
		end
		if (sel.primary == LAYOUT_POS) begin
			next_primary[PSW_TOL]        = DRIVE_STATE.follow_err_in_tol;
			next_primary[PSW_REACHED]    = DRIVE_STATE.target_reached;
			next_primary[PSW_REF_SET]    = DRIVE_STATE.ref_point_set;
			next_primary[PSW_TASK_ACK]   = ack_bit;
			next_primary[PSW_STANDSTILL] = DRIVE_STATE.standstill;
		end
	end

	// ==================== Secondary and auxiliary word assembly ====================
	always_comb begin
		next_secondary = WORD_RESET;
		next_aux       = WORD_RESET;
		if (sel.secondary != LAYOUT_NONE) begin
			next_secondary[SSW_FIXED_STOP] = DRIVE_STATE.fixed_stop_active;
			next_secondary[SSW_LIFE_LSB +: LIFE_W] = life;
		end
		if (sel.secondary == LAYOUT_SPEED) begin
			next_secondary[SSW_RAMP_BYPASS] = DRIVE_STATE.ramp_bypassed;
			next_secondary[SSW_BRAKE_OPEN]  = DRIVE_STATE.brake_released;
			next_secondary[SSW_INTEG_INH]   = DRIVE_STATE.integ_inhibited;
		end
		if (sel.aux_en) begin
			next_aux[AUX_INCHING]   = DRIVE_STATE.inching_function;
			next_aux[AUX_HOMING]    = DRIVE_STATE.homing_active;
			next_aux[AUX_DIRECT_SP] = DRIVE_STATE.direct_setpoint_input_mode;
		end
	end

	// ==================== Transmit registers ====================
	// Words are snapshots taken on the cycle strobe, so the host sees a
	// coherent set even while the drive state changes between cycles.
	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			PRIMARY_STATUS_WORD         <= WORD_RESET;
			SECONDARY_STATUS_WORD       <= WORD_RESET;
			POSITIONING_AUX_STATUS_WORD <= WORD_RESET;
			sent_sel                    <= '{primary: LAYOUT_NONE, secondary: LAYOUT_NONE,
			                                 aux_en: 1'b0, supported: 1'b0};
		end else if (CYCLE_TICK) begin
			PRIMARY_STATUS_WORD         <= next_primary;
			SECONDARY_STATUS_WORD       <= next_secondary;
			POSITIONING_AUX_STATUS_WORD <= next_aux;
			sent_sel                    <= sel;
		end
	end

	// Valid pulse follows the strobe; the telegram flag is registered on every clock
	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			STATUS_VALID         <= 1'b0;
			TELEGRAM_UNSUPPORTED <= 1'b0;
		end else begin
			STATUS_VALID         <= CYCLE_TICK;
			TELEGRAM_UNSUPPORTED <= !sel.supported;
		end
	end

	// ==================== Assertions ====================
	property p_control_bits;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(CYCLE_TICK && sel.supported) |=>
			PRIMARY_STATUS_WORD[PSW_ON_READY] == $past(DRIVE_STATE.servo_ready) &&
			PRIMARY_STATUS_WORD[PSW_READY_RUN] == $past(DRIVE_STATE.ready_to_run) &&
			PRIMARY_STATUS_WORD[PSW_RUN_EN] == $past(DRIVE_STATE.run_enabled) &&
			PRIMARY_STATUS_WORD[PSW_CTRL_REQ] == $past(DRIVE_STATE.control_request);
	endproperty
	a_control_bits: assert property (p_control_bits) else $error("Ready or request bit wrong");

	property p_fault_bits;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(CYCLE_TICK && sel.supported) |=>
			PRIMARY_STATUS_WORD[PSW_FAULT] == $past(DRIVE_STATE.fault) &&
			PRIMARY_STATUS_WORD[PSW_SW_INHIBIT] == $past(DRIVE_STATE.switch_on_inhibit) &&
			PRIMARY_STATUS_WORD[PSW_ALARM] == $past(DRIVE_STATE.alarm);
	endproperty
	a_fault_bits: assert property (p_fault_bits) else $error("Fault or alarm bit wrong");

	property p_stop_bits;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(CYCLE_TICK && sel.supported) |=>
			PRIMARY_STATUS_WORD[PSW_NO_COAST] != $past(DRIVE_STATE.coast_stop_command) &&
			PRIMARY_STATUS_WORD[PSW_NO_QUICK] != $past(DRIVE_STATE.quick_stop_command);
	endproperty
	a_stop_bits: assert property (p_stop_bits) else $error("Stop bits not inverted");

	property p_speed_layout;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(CYCLE_TICK && sel.primary == LAYOUT_SPEED) |=>
			PRIMARY_STATUS_WORD[PSW_TOL] == $past(DRIVE_STATE.speed_in_tol) &&
			PRIMARY_STATUS_WORD[PSW_REACHED] == $past(DRIVE_STATE.compare_reached) &&
			PRIMARY_STATUS_WORD[PSW_TORQUE_CTRL] == $past(DRIVE_STATE.torque_ctrl);
	endproperty
	a_speed_layout: assert property (p_speed_layout) else $error("Speed layout bits wrong");

	property p_pos_layout;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(CYCLE_TICK && sel.primary == LAYOUT_POS) |=>
			PRIMARY_STATUS_WORD[PSW_TOL] == $past(DRIVE_STATE.follow_err_in_tol) &&
			PRIMARY_STATUS_WORD[PSW_REACHED] == $past(DRIVE_STATE.target_reached) &&
			PRIMARY_STATUS_WORD[PSW_REF_SET] == $past(DRIVE_STATE.ref_point_set) &&
			PRIMARY_STATUS_WORD[PSW_STANDSTILL] == $past(DRIVE_STATE.standstill);
	endproperty
	a_pos_layout: assert property (p_pos_layout) else $error("Positioning layout bits wrong");

	property p_task_ack;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(CYCLE_TICK && ack_state == ACK_DROP && sel.primary == LAYOUT_POS) |=>
			!PRIMARY_STATUS_WORD[PSW_TASK_ACK] ##0 (ack_state == ACK_SET || sel.primary != LAYOUT_POS);
	endproperty
	a_task_ack: assert property (p_task_ack) else $error("Task acknowledge edge not forced");

	property p_life_sign;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(CYCLE_TICK && sel.secondary != LAYOUT_NONE) |=>
			SECONDARY_STATUS_WORD[15:12] == $past(life) && life == 4'($past(life) + LIFE_STEP);
	endproperty
	a_life_sign: assert property (p_life_sign) else $error("Life sign not placed or stepped");

	property p_secondary_bits;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(CYCLE_TICK && sel.secondary == LAYOUT_SPEED) |=>
			SECONDARY_STATUS_WORD[SSW_FIXED_STOP] == $past(DRIVE_STATE.fixed_stop_active) &&
			SECONDARY_STATUS_WORD[SSW_RAMP_BYPASS] == $past(DRIVE_STATE.ramp_bypassed) &&
			SECONDARY_STATUS_WORD[SSW_BRAKE_OPEN] == $past(DRIVE_STATE.brake_released) &&
			SECONDARY_STATUS_WORD[SSW_INTEG_INH] == $past(DRIVE_STATE.integ_inhibited);
	endproperty
	a_secondary_bits: assert property (p_secondary_bits) else $error("Extended secondary bits wrong");

	property p_aux_bits;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(CYCLE_TICK && sel.aux_en) |=>
			POSITIONING_AUX_STATUS_WORD[AUX_INCHING] == $past(DRIVE_STATE.inching_function) &&
			POSITIONING_AUX_STATUS_WORD[AUX_HOMING] == $past(DRIVE_STATE.homing_active) &&
			POSITIONING_AUX_STATUS_WORD[AUX_DIRECT_SP] == $past(DRIVE_STATE.direct_setpoint_input_mode);
	endproperty
	a_aux_bits: assert property (p_aux_bits) else $error("Auxiliary word bits wrong");

	property p_reserved_zero;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		STATUS_VALID |->
			(sent_sel.primary != LAYOUT_GENERAL || (PRIMARY_STATUS_WORD & RSV_PRI_GENERAL) == WORD_RESET) &&
			(sent_sel.primary != LAYOUT_SPEED || (PRIMARY_STATUS_WORD & RSV_PRI_SPEED) == WORD_RESET) &&
			(sent_sel.primary != LAYOUT_POS || (PRIMARY_STATUS_WORD & RSV_PRI_POS) == WORD_RESET) &&
			(sent_sel.secondary != LAYOUT_GENERAL || (SECONDARY_STATUS_WORD & RSV_SEC_GENERAL) == WORD_RESET) &&
			(sent_sel.secondary != LAYOUT_SPEED || (SECONDARY_STATUS_WORD & RSV_SEC_SPEED) == WORD_RESET) &&
			(POSITIONING_AUX_STATUS_WORD & RSV_AUX) == WORD_RESET;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit set");

	property p_layout_select;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(CYCLE_TICK && TELEGRAM == TEL_POS111) |=>
			sent_sel.primary == LAYOUT_POS && sent_sel.secondary == LAYOUT_GENERAL && STATUS_VALID;
	endproperty
	a_layout_select: assert property (p_layout_select) else $error("Telegram 111 layout wrong");

	property p_general_secondary;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(CYCLE_TICK && sel.secondary == LAYOUT_GENERAL) |=>
			SECONDARY_STATUS_WORD[SSW_FIXED_STOP] == $past(DRIVE_STATE.fixed_stop_active);
	endproperty
	a_general_secondary: assert property (p_general_secondary) else $error("General secondary bit wrong");

	// A refused telegram must not leak any drive state to the host
	property p_unsupported_zero;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(CYCLE_TICK && !sel.supported) |=>
			PRIMARY_STATUS_WORD == WORD_RESET && SECONDARY_STATUS_WORD == WORD_RESET &&
			POSITIONING_AUX_STATUS_WORD == WORD_RESET && TELEGRAM_UNSUPPORTED;
	endproperty
	a_unsupported_zero: assert property (p_unsupported_zero) else $error("Unsupported telegram word not zero");

	// Without a strobe the host must keep reading the last coherent set
	property p_words_hold;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		!CYCLE_TICK |=>
			$stable(PRIMARY_STATUS_WORD) && $stable(SECONDARY_STATUS_WORD) &&
			$stable(POSITIONING_AUX_STATUS_WORD) && !STATUS_VALID;
	endproperty
	a_words_hold: assert property (p_words_hold) else $error("Words changed without a cycle strobe");

	property p_valid_pulse;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		CYCLE_TICK |=> STATUS_VALID;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("Valid pulse missing after strobe");

	property p_ack_rise;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(ack_state == ACK_IDLE && TASK_ACCEPTED && sel.primary == LAYOUT_POS) |=> ack_state == ACK_SET;
	endproperty
	a_ack_rise: assert property (p_ack_rise) else $error("Accepted task not acknowledged");

	property p_ack_release;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(ack_state == ACK_SET && !TASK_ACCEPTED && !TASK_ACTIVATE) |=> ack_state == ACK_IDLE;
	endproperty
	a_ack_release: assert property (p_ack_release) else $error("Task acknowledge not released");

	// Main scenarios reached
	c_speed_word: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
		CYCLE_TICK && sel.primary == LAYOUT_SPEED);
	c_task_ack: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
		CYCLE_TICK && ack_state == ACK_DROP);
	c_life_wrap: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
		CYCLE_TICK && life == 4'hf);
	c_unsupported: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
		CYCLE_TICK && !sel.supported);

endmodule
`default_nettype wire

// ### tb/host_controller_model.sv
// Host controller model: issues cycle strobes, holds task activate, receives status words
`timescale 1ns/1ps
`default_nettype none
module host_controller_model (
	// Clock
	input  wire logic        CLK_SYS,
	// Received status words
	input  wire logic [15:0] PRIMARY_STATUS_WORD,
	input  wire logic [15:0] SECONDARY_STATUS_WORD,
	input  wire logic        STATUS_VALID,
	// Cyclic requests
	output logic             CYCLE_TICK,
	output logic             TASK_ACTIVATE
);
	// ==================== Host control words ====================
	// Kept inside the model: the packer under test does not decode control words
	logic [15:0] secondary_control_word = 16'h0000;
	logic [15:0] primary_control_word   = 16'h0000;
	logic        timed_out              = 1'b0;

	// Requests idle until the bench asks for an exchange
	initial begin
		CYCLE_TICK    = 1'b0;
		TASK_ACTIVATE = 1'b0;
	end

	// One exchange: strobe for one clock, then wait a bounded time for the answer
	task automatic exchange();
		int n;
		n = 0;
		@(posedge CLK_SYS);
		#1 CYCLE_TICK = 1'b1;
		secondary_control_word[15:12] = secondary_control_word[15:12] + 4'h1;
		@(posedge CLK_SYS);
		#1 CYCLE_TICK = 1'b0;
		while (STATUS_VALID !== 1'b1 && n < 8) begin
			@(posedge CLK_SYS);
			n++;
		end
		timed_out = (STATUS_VALID !== 1'b1);
	endtask

	// Task activate is a level the host holds until it has seen the acknowledge
	task automatic set_activate(logic v);
		@(posedge CLK_SYS);
		#1 TASK_ACTIVATE = v;
	endtask

	// Fault acknowledge is a fresh rising edge on control bit 7
	task automatic ack_fault();
		primary_control_word[7] = 1'b0;
		@(posedge CLK_SYS);
		#1 primary_control_word[7] = 1'b1;
	endtask
endmodule
`default_nettype wire

// ### tb/drive_status_word_packer_tb.sv
// Self-checking testbench of the status word packer
`timescale 1ns/1ps
`default_nettype none
module drive_status_word_packer_tb;
	import drive_status_pkg::*;
	// ==================== Signals ====================
	logic         clk_sys       = 1'b0;
	logic         reset_n       = 1'b0;
	logic [7:0]   telegram      = 8'h01;
	drive_state_t drive_state   = '0;
	logic         task_accepted = 1'b0;
	logic         cycle_tick;
	logic         task_activate;
	logic [15:0]  pri;
	logic [15:0]  sec;
	logic [15:0]  aux;
	logic         status_valid;
	logic         unsupported;
	logic [3:0]   life          = 4'h0;
	int           n_mismatch    = 0;
	int           checks_done   = 0;
	int           cycles        = 0;
	drive_state_t pats [3]      = '{'1, '0, 23'h2aaaaa};
	logic [7:0]   tels [7]      = '{8'h00, 8'h70, 8'h01, 8'h03, 8'h66, 8'h69, 8'h6f};

	// ==================== Clock and instances ====================
	always #2.5 clk_sys = ~clk_sys;

	drive_status_word_packer u_dut (
		.CLK_SYS                     (clk_sys),
		.RESET_N                     (reset_n),
		.TELEGRAM                    (telegram),
		.CYCLE_TICK                  (cycle_tick),
		.DRIVE_STATE                 (drive_state),
		.TASK_ACTIVATE               (task_activate),
		.TASK_ACCEPTED               (task_accepted),
		.PRIMARY_STATUS_WORD         (pri),
		.SECONDARY_STATUS_WORD       (sec),
		.POSITIONING_AUX_STATUS_WORD (aux),
		.STATUS_VALID                (status_valid),
		.TELEGRAM_UNSUPPORTED        (unsupported)
	);

	host_controller_model u_host (
		.CLK_SYS               (clk_sys),
		.PRIMARY_STATUS_WORD   (pri),
		.SECONDARY_STATUS_WORD (sec),
		.STATUS_VALID          (status_valid),
		.CYCLE_TICK            (cycle_tick),
		.TASK_ACTIVATE         (task_activate)
	);

	// ==================== Expected words ====================
	function automatic logic is_spd(logic [7:0] t);
		return t == 8'h66 || t == 8'h69;
	endfunction

	function automatic logic is_ok(logic [7:0] t);
		return t == 8'h01 || t == 8'h03 || t == 8'h6f || is_spd(t);
	endfunction

	function automatic logic [15:0] exp_pri(logic [7:0] t, drive_state_t s, logic ack);
		logic [15:0] w;
		w = 16'h0000;
		w[9:0] = {s.control_request, 1'b0, s.alarm, s.switch_on_inhibit, ~s.quick_stop_command,
			~s.coast_stop_command, s.fault, s.run_enabled, s.ready_to_run, s.servo_ready};
		if (t == 8'h6f) begin
			w[13:8] = {s.standstill, ack, s.ref_point_set, s.target_reached, w[9], s.follow_err_in_tol};
		end else begin
			w[8] = s.speed_in_tol;
			w[10] = s.compare_reached;
			w[14] = is_spd(t) & s.torque_ctrl;
		end
		return is_ok(t) ? w : 16'h0000;
	endfunction

	function automatic logic [15:0] exp_sec(logic [7:0] t, drive_state_t s, logic [3:0] l);
		logic [15:0] w;
		w = {l, 3'h0, s.fixed_stop_active, 8'h00};
		if (is_spd(t)) begin
			w[6:4] = {s.integ_inhibited, s.brake_released, s.ramp_bypassed};
		end
		return is_ok(t) ? w : 16'h0000;
	endfunction

	function automatic logic [15:0] exp_aux(logic [7:0] t, drive_state_t s);
		logic [15:0] w;
		w = {s.direct_setpoint_input_mode, 3'h0, s.homing_active, s.inching_function, 10'h000};
		return (t == 8'h6f) ? w : 16'h0000;
	endfunction

	// ==================== Checking tasks ====================
	task automatic check(logic [15:0] got, logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One status exchange compared word by word; the life sign advances on every tick
	task automatic send(logic ack);
		u_host.exchange();
		check({15'h0, status_valid}, 16'h0001);
		check({15'h0, u_host.timed_out}, 16'h0000);
		check(pri, exp_pri(telegram, drive_state, ack));
		check(sec, exp_sec(telegram, drive_state, life));
		check(aux, exp_aux(telegram, drive_state));
		check({15'h0, unsupported}, {15'h0, ~is_ok(telegram)});
		life = life + 4'h1;
	endtask

	task automatic pulse_accept();
		@(posedge clk_sys);
		#1 task_accepted = 1'b1;
		@(posedge clk_sys);
		#1 task_accepted = 1'b0;
	endtask

	task automatic conclude();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ==================== Hang guard ====================
	// The whole sequence needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			conclude();
		end
	end

	// ==================== Main sequence ====================
	initial begin
		repeat (2) @(posedge clk_sys);
		#1 reset_n = 1'b1;
		// Every telegram against every state pattern; 21 ticks also wrap the life sign
		foreach (tels[i]) begin
			foreach (pats[j]) begin
				telegram = tels[i];
				drive_state = pats[j];
				send(1'b0);
			end
		end
		u_host.ack_fault();
		// Words stand between ticks even while the drive state moves
		drive_state = ~drive_state;
		repeat (3) @(posedge clk_sys);
		#1 check(pri, exp_pri(telegram, ~drive_state, 1'b0));
		check(sec, exp_sec(telegram, ~drive_state, life - 4'h1));
		check(aux, exp_aux(telegram, ~drive_state));
		check({15'h0, status_valid}, 16'h0000);
		// Task acknowledge: fresh edge, forced drop on a second accept, release on deactivate
		telegram = 8'h6f;
		drive_state = '0;
		u_host.set_activate(1'b1);
		pulse_accept();
		send(1'b1);
		pulse_accept();
		send(1'b0);
		send(1'b1);
		u_host.set_activate(1'b0);
		@(posedge clk_sys);
		send(1'b0);
		// Reset in mid-run clears the words and restarts the life sign
		@(posedge clk_sys);
		#1 reset_n = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 check(pri | sec | aux, 16'h0000);
		check({14'h0, status_valid, unsupported}, 16'h0000);
		reset_n = 1'b1;
		life = 4'h0;
		drive_state = '1;
		send(1'b0);
		conclude();
	end
endmodule
`default_nettype wire
